// *** pkg/phase_pipe_defs.vh ***
// Constants for the instruction phase pipeline.
`ifndef PHASE_PIPE_DEFS_VH
`define PHASE_PIPE_DEFS_VH
`define PH_T1 2'h0
`define PH_T2 2'h1
`define PH_T3 2'h2
`define PH_T4 2'h3
`define RESET_VECTOR 14'h0000
`define PAGE_MASK 14'h3F00
`define OP_NOP 3'h0
`define OP_ADD 3'h1
`define OP_AND 3'h2
`define OP_OR 3'h3
`define OP_XOR 3'h4
`define OP_INC 3'h5
`define OP_DEC 3'h6
`define OP_RL 3'h7
`endif

// *** design/alu8.v ***
// Eight-bit arithmetic unit shared by all data and branch-decision operations.
`timescale 1ns/1ps
`include "phase_pipe_defs.vh"
module alu8 (
  input wire clk_in,
  input wire rst_in,
  input wire load_in,
  input wire [2:0] op_in,
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  output reg [7:0] result_out,
  output reg zero_out
);
  reg [7:0] res_nxt;
  always @* begin
    case (op_in)
      `OP_ADD: res_nxt = a_in + b_in;
      `OP_AND: res_nxt = a_in & b_in;
      `OP_OR: res_nxt = a_in | b_in;
      `OP_XOR: res_nxt = a_in ^ b_in;
      `OP_INC: res_nxt = b_in + 8'h01;
      `OP_DEC: res_nxt = b_in - 8'h01;
      `OP_RL: res_nxt = {b_in[6:0], b_in[7]};
      default: res_nxt = a_in;
    endcase
  end
  always @(posedge clk_in) begin
    if (rst_in) begin
      result_out <= 8'h00;
      zero_out <= 1'b0;
    end else if (load_in) begin
      result_out <= res_nxt;
      zero_out <= (res_nxt == 8'h00);
    end
  end
endmodule // alu8

// *** design/instruction_phase_pipeline.v ***
// Four-phase instruction sequencer with fetch/execute overlap and branch flush.
// Notes on behaviour
// - Four non-overlapping phases from the system clock form one instruction cycle.
// - Program counter increments at first phase start; new word fetched then.
// - Phases two to four decode and execute the previously fetched word.
// - Fetch overlaps execute, so plain instructions finish one per cycle.
// - Program counter changing instructions take two instruction cycles.
// - With RC oscillator selected, spare pin carries first-phase clock, 1:3 duty.
// - One 8-bit arithmetic unit does all operations; data moves through accumulator.
// - Taken skip discards prefetched word and runs a dummy cycle instead.
// - Write to counter low byte jumps within page and inserts dummy cycle.
`timescale 1ns/1ps
`include "phase_pipe_defs.vh"
module instruction_phase_pipeline #(
  parameter PC_W = 14
) (
  input wire clk_in,
  input wire rst_in,
  input wire rc_osc_sel_in,
  input wire [15:0] instr_word_in,
  input wire exec_op_valid_in,
  input wire [2:0] exec_op_in,
  input wire [7:0] exec_operand_in,
  input wire branch_in,
  input wire [PC_W-1:0] branch_target_in,
  input wire skip_in,
  input wire pcl_write_in,
  input wire [7:0] pcl_data_in,
  output wire [3:0] instruction_phase_clocks_out,
  output reg [PC_W-1:0] fetch_addr_out,
  output reg fetch_strobe_out,
  output reg [15:0] exec_instr_out,
  output reg exec_valid_out,
  output reg exec_dummy_out,
  output reg [7:0] accumulator_out,
  output wire alu_zero_out,
  output reg spare_oscillator_output_pin_out,
  output reg spare_oscillator_output_pin_oe_out
);
  localparam [PC_W-1:0] PC_STEP = {{(PC_W-1){1'b0}}, 1'b1};

  // Pipeline state: phase counter, fetch counter, prefetch slot and pending redirect.
  reg [1:0] phase_r;
  reg [PC_W-1:0] pc_r;
  reg [PC_W-1:0] pc_nxt;
  reg [PC_W-1:0] fetch_addr_nxt;
  reg [15:0] prefetch_r;
  reg prefetch_valid_r;
  reg flush_r;
  reg flush_nxt;
  reg [PC_W-1:0] redirect_r;
  reg [PC_W-1:0] redirect_nxt;
  wire [7:0] alu_result;
  wire cycle_end;
  wire fetch_now;
  wire req_open;
  wire alu_load;
  wire acc_load;
  wire pin_nxt;

  // True when the sequencer sits in the given phase.
  function phase_is;
    input [1:0] cur;
    input [1:0] want;
    begin
      phase_is = (cur == want);
    end
  endfunction

  // A low-byte write keeps the page bits, so such a jump can never leave the current 256-word page.
  function [PC_W-1:0] page_jump;
    input [PC_W-1:0] pc;
    input [7:0] low;
    begin
      page_jump = {pc[PC_W-1:8], low};
    end
  endfunction

  assign cycle_end = phase_is(phase_r, `PH_T4);
  assign fetch_now = phase_is(phase_r, `PH_T1) && fetch_strobe_out;
  // Requests are heard in phases two and three only; a later one could not steer the next fetch in time.
  assign req_open = (phase_is(phase_r, `PH_T2) || phase_is(phase_r, `PH_T3)) && exec_valid_out && !flush_r;
  assign alu_load = phase_is(phase_r, `PH_T3) && exec_valid_out && exec_op_valid_in;
  assign acc_load = phase_is(phase_r, `PH_T4) && exec_valid_out && exec_op_valid_in;
  assign pin_nxt = rc_osc_sel_in && cycle_end;

  // Phase decode as a one-hot vector guarantees the phases never overlap.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ph_dec
      assign instruction_phase_clocks_out[g] = (phase_r == g[1:0]);
    end
  endgenerate

  // The counter wraps from the last phase back to the first, one instruction cycle per lap.
  always @(posedge clk_in) begin
    if (rst_in) begin
      phase_r <= `PH_T1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Next fetch address: the redirect target after a flush, else the counter.
  always @* begin
    if (flush_r) begin
      fetch_addr_nxt = redirect_r;
    end else begin
      fetch_addr_nxt = pc_r;
    end
    pc_nxt = fetch_addr_nxt + PC_STEP;
  end

  // The strobe is registered from the last phase so that it stands for the whole first phase.
  always @(posedge clk_in) begin
    if (rst_in) begin
      pc_r <= `RESET_VECTOR;
      fetch_addr_out <= `RESET_VECTOR;
      fetch_strobe_out <= 1'b0;
    end else begin
      fetch_strobe_out <= cycle_end;
      if (cycle_end) begin
        fetch_addr_out <= fetch_addr_nxt;
        pc_r <= pc_nxt;
      end
    end
  end

  // The word is only taken in a first phase that carries a strobe, so the idle
  // first phase straight after reset cannot load a stale bus value.
  always @(posedge clk_in) begin
    if (rst_in) begin
      prefetch_r <= 16'h0000;
      prefetch_valid_r <= 1'b0;
    end else if (fetch_now) begin
      prefetch_r <= instr_word_in;
      prefetch_valid_r <= 1'b1;
    end
  end

  // A request is held until the cycle ends, and only the first in a cycle is taken.
  always @* begin
    flush_nxt = flush_r;
    redirect_nxt = redirect_r;
    if (cycle_end) begin
      flush_nxt = 1'b0;
    end else if (req_open) begin
      if (branch_in) begin
        flush_nxt = 1'b1;
        redirect_nxt = branch_target_in;
      end else if (pcl_write_in) begin
        flush_nxt = 1'b1;
        redirect_nxt = page_jump(pc_r, pcl_data_in);
      end else if (skip_in) begin
        // Skipping resumes at the counter, past the word already prefetched.
        flush_nxt = 1'b1;
        redirect_nxt = pc_r;
      end
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      flush_r <= 1'b0;
      redirect_r <= `RESET_VECTOR;
    end else begin
      flush_r <= flush_nxt;
      redirect_r <= redirect_nxt;
    end
  end

  // Next cycle starts: the prefetched word moves into execute, or a dummy takes its place.
  // A dummy is only flagged when a real word was discarded, not while the pipeline fills.
  always @(posedge clk_in) begin
    if (rst_in) begin
      exec_instr_out <= 16'h0000;
      exec_valid_out <= 1'b0;
      exec_dummy_out <= 1'b0;
    end else if (cycle_end) begin
      if (flush_r || !prefetch_valid_r) begin
        exec_instr_out <= 16'h0000;
        exec_valid_out <= 1'b0;
        exec_dummy_out <= prefetch_valid_r;
      end else begin
        exec_instr_out <= prefetch_r;
        exec_valid_out <= 1'b1;
        exec_dummy_out <= 1'b0;
      end
    end
  end

  // The shared arithmetic unit registers its result in the third phase.
  alu8 u_alu (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(alu_load),
    .op_in(exec_op_in),
    .a_in(accumulator_out),
    .b_in(exec_operand_in),
    .result_out(alu_result),
    .zero_out(alu_zero_out)
  );

  // The accumulator takes the result one phase later, so both stay on one clock.
  always @(posedge clk_in) begin
    if (rst_in) begin
      accumulator_out <= 8'h00;
    end else if (acc_load) begin
      accumulator_out <= alu_result;
    end
  end

  // Registered so the pin stays glitch free; high during first phase only gives 1:3.
  always @(posedge clk_in) begin
    if (rst_in) begin
      spare_oscillator_output_pin_out <= 1'b0;
      spare_oscillator_output_pin_oe_out <= 1'b0;
    end else begin
      spare_oscillator_output_pin_out <= pin_nxt;
      spare_oscillator_output_pin_oe_out <= rc_osc_sel_in;
    end
  end
endmodule // instruction_phase_pipeline

// *** test/phase_chk.sv ***
// Concurrent checks on the phase sequencer ports.
`timescale 1ns/1ps
module phase_chk #(parameter PC_W = 14) (
  input wire clk_in,
  input wire rst_in,
  input wire rc_osc_sel_in,
  input wire branch_in,
  input wire skip_in,
  input wire pcl_write_in,
  input wire [3:0] instruction_phase_clocks_out,
  input wire [PC_W-1:0] fetch_addr_out,
  input wire fetch_strobe_out,
  input wire exec_valid_out,
  input wire exec_dummy_out,
  input wire spare_oscillator_output_pin_out
);
  wire [3:0] ph = instruction_phase_clocks_out;
  wire fs = fetch_strobe_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence cyc_s; ph[1] ##1 ph[2] ##1 ph[3] ##1 ph[0]; endsequence
  // A redirect leaves a dummy slot, and the target runs one cycle after it.
  sequence redir_s; ##[1:7] (fs && exec_dummy_out && !exec_valid_out) ##4 exec_valid_out; endsequence
  property redir_p(r); ph[1] && exec_valid_out && r |-> redir_s; endproperty
  a_phase_rotate: assert property (ph[0] |=> cyc_s) else $error("bad phase order");
  a_strobe_phase: assert property (fs |-> ph[0]) else $error("strobe off first phase");
  a_strobe_period: assert property (fs |=> !fs [*3] ##1 fs) else $error("strobe period");
  a_fetch_step: assert property (fs ##4 (fs && !exec_dummy_out) |->
    fetch_addr_out == $past(fetch_addr_out, 4) + 1'b1) else $error("fetch step");
  a_spare_pin: assert property (rc_osc_sel_in && $past(rc_osc_sel_in) && !$past(rst_in) |->
    spare_oscillator_output_pin_out == ph[0]) else $error("spare pin");
  a_branch_dummy: assert property (redir_p(branch_in)) else $error("branch timing");
  a_skip_dummy: assert property (redir_p(skip_in)) else $error("skip timing");
  a_pcl_dummy: assert property (redir_p(pcl_write_in)) else $error("low byte jump timing");
endmodule // phase_chk
bind instruction_phase_pipeline phase_chk #(.PC_W(PC_W)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .rc_osc_sel_in(rc_osc_sel_in), .branch_in(branch_in), .skip_in(skip_in), .pcl_write_in(pcl_write_in),
  .instruction_phase_clocks_out(instruction_phase_clocks_out), .fetch_addr_out(fetch_addr_out),
  .fetch_strobe_out(fetch_strobe_out), .exec_valid_out(exec_valid_out), .exec_dummy_out(exec_dummy_out),
  .spare_oscillator_output_pin_out(spare_oscillator_output_pin_out));

// *** test/prog_mem.sv ***
// Program memory model returning a word built from its address.
`timescale 1ns/1ps
module prog_mem (
  input wire fetch_strobe_in,
  input wire [13:0] addr_in,
  output logic [15:0] word_out
);
  // Outside a fetch the bus shows the inverted word, so a mistimed sample is caught.
  assign word_out = fetch_strobe_in ? {2'h1, addr_in} : ~{2'h1, addr_in};
endmodule // prog_mem

// *** test/instruction_phase_pipeline_tb.sv ***
// Self-checking bench for the instruction phase pipeline.
`timescale 1ns/1ps
`include "phase_pipe_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t mismatch", $time); end end
module instruction_phase_pipeline_tb;
  logic clk_in = 0, rst_in = 1, rc = 0, opv = 0, br = 0, sk = 0, pw = 0;
  logic [2:0] op = 3'h0;
  logic [7:0] opd = 8'h00, pd = 8'hF0;
  logic [13:0] tgt = 14'h0155;
  wire [15:0] word, ins;
  wire [13:0] fa;
  wire [3:0] ph;
  wire [7:0] acc;
  wire fs, ev, ed, az, pin, oe;
  int err_total = 0, n_checks = 0;
  always #5 clk_in = ~clk_in;
  prog_mem mem (.fetch_strobe_in(fs), .addr_in(fa), .word_out(word));
  instruction_phase_pipeline DUT (.clk_in(clk_in), .rst_in(rst_in), .rc_osc_sel_in(rc), .instr_word_in(word),
    .exec_op_valid_in(opv), .exec_op_in(op), .exec_operand_in(opd), .branch_in(br), .branch_target_in(tgt),
    .skip_in(sk), .pcl_write_in(pw), .pcl_data_in(pd), .instruction_phase_clocks_out(ph), .fetch_addr_out(fa),
    .fetch_strobe_out(fs), .exec_instr_out(ins), .exec_valid_out(ev), .exec_dummy_out(ed),
    .accumulator_out(acc), .alu_zero_out(az), .spare_oscillator_output_pin_out(pin),
    .spare_oscillator_output_pin_oe_out(oe));
  task automatic complete_run;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wt;
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_in);
      if (fs && ev) break;
    end
    if (i == 40) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic redir(input int k);
    logic [13:0] a, e;
    wt();
    a = fa + 14'h1;
    e = k == 0 ? tgt : k == 1 ? {a[13:8], pd} : a;
    @(negedge clk_in);
    {br, pw, sk} = 3'b100 >> k;
    @(negedge clk_in);
    {br, pw, sk} = 3'h0;
    repeat (2) @(negedge clk_in);
    `CHK({fs, ed, ev, fa}, {3'h6, e})
    repeat (4) @(negedge clk_in);
    `CHK({ev, ins}, {1'b1, 2'h1, e})
  endtask
  task automatic alu(input logic [2:0] c, input logic [7:0] d, input logic [8:0] x);
    wt();
    {opv, op, opd} = {1'b1, c, d};
    repeat (4) @(negedge clk_in);
    opv = 0;
    repeat (4) @(negedge clk_in);
    `CHK({az, acc}, x)
  endtask
  task automatic release_check;
    int i;
    rst_in = 0;
    for (i = 0; i < 20 && !fs; i++) @(negedge clk_in);
    if (i == 20) begin
      err_total++;
      complete_run();
    end
    `CHK({fs, ev, ed, fa, i}, {3'h4, 14'h0000, 32'h4})
    repeat (4) @(negedge clk_in);
    `CHK({ev, ed, ins, fa}, {2'h2, 16'h4000, 14'h0001})
  endtask
  task automatic reset_start;
    repeat (20) @(negedge clk_in);
    `CHK({ph, fs, ev, ed, acc, oe, pin}, {4'h1, 3'h0, 8'h00, 2'h0})
    release_check();
  endtask
  task automatic mid_reset;
    rst_in = 1;
    repeat (3) @(negedge clk_in);
    `CHK({ph, fs, ev, ed, acc, az, oe, pin}, {4'h1, 3'h0, 8'h00, 3'h0})
    release_check();
  endtask
  task automatic steady;
    logic [13:0] a;
    wt();
    a = fa;
    repeat (4) @(negedge clk_in);
    `CHK({ev, ed, fa, ins}, {2'h2, a + 14'h1, 2'h1, a})
  endtask
  task automatic spare_pin;
    `CHK({oe, pin}, 2'h0)
    rc = 1;
    repeat (2) @(negedge clk_in);
    for (int i = 0; i < 8; i++) begin
      `CHK({oe, pin, ph}, {1'b1, i % 4 == 2, 4'h1 << ((i + 2) % 4)})
      @(negedge clk_in);
    end
  endtask
  initial begin
    reset_start();
    steady();
    for (int k = 0; k < 3; k++) redir(k);
    alu(`OP_ADD, 8'h3C, 9'h03C);
    alu(`OP_XOR, 8'h3C, 9'h100);
    alu(`OP_OR, 8'hA5, 9'h0A5);
    alu(`OP_AND, 8'h0F, 9'h005);
    alu(`OP_INC, 8'h7F, 9'h080);
    alu(`OP_DEC, 8'h01, 9'h100);
    alu(`OP_RL, 8'h81, 9'h003);
    alu(`OP_NOP, 8'hFF, 9'h003);
    alu(`OP_ADD, 8'h5A, 9'h05D);
    spare_pin();
    mid_reset();
    complete_run();
  end
endmodule // instruction_phase_pipeline_tb
